// ### design/ppt_timer.sv
// Contract
// - Clock-select field picks none or three rates
// - Cycle length is period plus one ticks
// - Output high when count reaches threshold
// - Invert bit flips output polarity
// - Enable bit plus pin routing needed
// - Each cycle begins with output low unless threshold is zero
// - High span is threshold through period
// - Threshold is sixteen-bit writable field
`timescale 1ns/1ps
`default_nettype none
module ppt_timer
  import ppt_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Pin routing
  input wire logic clkout_sel_timer,
  output logic clk_out,
  // State
  output logic timer_out
);
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] ctl_ff, nxt_ctl;
  logic [15:0] per_ff, nxt_per;
  logic [15:0] thr_ff, nxt_thr;
  logic [15:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_per = per_ff;
    nxt_thr = thr_ff;
    nxt_rdata = rdata_ff;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_TIMER_CONTROL: nxt_ctl = reg_wdata & CTL_WRITE_MASK;
        ADDR_TIMER_PERIOD_LENGTH: nxt_per = reg_wdata;
        ADDR_TIMER_COMPARE_THRESHOLD: nxt_thr = reg_wdata;
        default: nxt_ctl = ctl_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_TIMER_CONTROL: nxt_rdata = ctl_ff;
        ADDR_TIMER_PERIOD_LENGTH: nxt_rdata = per_ff;
        ADDR_TIMER_COMPARE_THRESHOLD: nxt_rdata = thr_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_ff <= RST_TIMER_CONTROL;
      per_ff <= RST_TIMER_PERIOD_LENGTH;
      thr_ff <= RST_TIMER_COMPARE_THRESHOLD;
      rdata_ff <= 16'h0000;
    end else begin
      ctl_ff <= nxt_ctl;
      per_ff <= nxt_per;
      thr_ff <= nxt_thr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ****************************************
  // Tick generation
  // ****************************************
  // Fractional accumulator: jitter of one ref_clk, exact mean rate
  logic [15:0] acc_ff, nxt_acc;
  logic [15:0] acc_sum;
  logic fast_tick_ff, nxt_fast_tick;
  logic mid_tick;
  logic slow_tick;

  always_comb begin
    acc_sum = acc_ff + ACC_STEP;
    nxt_acc = acc_sum;
    nxt_fast_tick = 1'b0;
    if (acc_sum >= ACC_MOD) begin
      nxt_acc = acc_sum - ACC_MOD;
      nxt_fast_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      acc_ff <= 16'h0000;
      fast_tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      fast_tick_ff <= nxt_fast_tick;
    end
  end

  ppt_tick_div #(.DIV(MID_DIV_CYC)) u_mid (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick_in(fast_tick_ff),
    .tick_out(mid_tick)
  );

  ppt_tick_div #(.DIV(SLOW_DIV_CYC)) u_slow (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick_in(mid_tick),
    .tick_out(slow_tick)
  );

  // ****************************************
  // Counter and output
  // ****************************************
  logic [1:0] clk_sel;
  logic enabled;
  logic tick;
  logic [15:0] cnt_ff, nxt_cnt;
  logic tout_ff, nxt_tout;
  logic pin_ff, nxt_pin;

  assign clk_sel = ctl_ff[CTL_CLKSEL_MSB:CTL_CLKSEL_LSB];
  assign enabled = ctl_ff[CTL_ENABLE_BIT] && (clk_sel != CLKSEL_NONE);

  always_comb begin
    case (clk_sel)
      CLKSEL_FAST: tick = fast_tick_ff;
      CLKSEL_MID: tick = mid_tick;
      CLKSEL_SLOW: tick = slow_tick;
      default: tick = 1'b0;
    endcase
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    if (!enabled) begin
      nxt_cnt = 16'h0000;
    end else if (tick) begin
      if (cnt_ff >= per_ff) begin
        nxt_cnt = 16'h0000;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
    // Compare on next count so output aligns with counter
    nxt_tout = enabled && (nxt_cnt >= thr_ff);
    nxt_tout = nxt_tout ^ ctl_ff[CTL_INVERT_BIT];
    // Pin is low unless both enable and routing are set
    nxt_pin = clkout_sel_timer && ctl_ff[CTL_ENABLE_BIT] && nxt_tout;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 16'h0000;
      tout_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tout_ff <= nxt_tout;
      pin_ff <= nxt_pin;
    end
  end

  assign timer_out = tout_ff;
  assign clk_out = pin_ff;

  // ****************************************
  // Checks
  // ****************************************
  property p_wrap;
    @(posedge ref_clk) disable iff (!resetn)
      (enabled && tick && cnt_ff >= per_ff) |=> (cnt_ff == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_step;
    @(posedge ref_clk) disable iff (!resetn)
      (enabled && tick && cnt_ff < per_ff && $stable(ctl_ff))
        |=> (cnt_ff == $past(cnt_ff) + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  property p_hold;
    @(posedge ref_clk) disable iff (!resetn)
      (!enabled) |=> (cnt_ff == 16'h0000);
  endproperty
  a_hold: assert property (p_hold) else $error("counter not held");

  property p_high;
    @(posedge ref_clk) disable iff (!resetn)
      (enabled && cnt_ff >= thr_ff && !ctl_ff[CTL_INVERT_BIT]
        && $stable(ctl_ff) && $stable(thr_ff)) |-> tout_ff;
  endproperty
  a_high: assert property (p_high) else $error("output not high");

  property p_low;
    @(posedge ref_clk) disable iff (!resetn)
      (enabled && cnt_ff < thr_ff && !ctl_ff[CTL_INVERT_BIT]
        && $stable(ctl_ff) && $stable(thr_ff)) |-> !tout_ff;
  endproperty
  a_low: assert property (p_low) else $error("output not low");

  property p_inv;
    @(posedge ref_clk) disable iff (!resetn)
      (enabled && ctl_ff[CTL_INVERT_BIT] && $stable(ctl_ff) && $stable(thr_ff))
        |-> (tout_ff == (cnt_ff < thr_ff));
  endproperty
  a_inv: assert property (p_inv) else $error("inversion wrong");

  property p_pin;
    @(posedge ref_clk) disable iff (!resetn)
      (!clkout_sel_timer || !ctl_ff[CTL_ENABLE_BIT]) |=> !clk_out;
  endproperty
  a_pin: assert property (p_pin) else $error("pin driven while unrouted");

  property p_none;
    @(posedge ref_clk) disable iff (!resetn)
      (clk_sel == CLKSEL_NONE) |-> !tick;
  endproperty
  a_none: assert property (p_none) else $error("tick with no clock");

  property p_thr;
    @(posedge ref_clk) disable iff (!resetn)
      (reg_wr && reg_addr == ADDR_TIMER_COMPARE_THRESHOLD) |=> (thr_ff == $past(reg_wdata));
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not written");
endmodule
`default_nettype wire

// ### inc/ppt_pkg.sv
`default_nettype none
package ppt_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [6:0] ADDR_TIMER_CONTROL = 7'h3B;
  localparam logic [6:0] ADDR_TIMER_PERIOD_LENGTH = 7'h3C;
  localparam logic [6:0] ADDR_TIMER_COMPARE_THRESHOLD = 7'h3D;
  localparam logic [15:0] RST_TIMER_CONTROL = 16'h0000;
  localparam logic [15:0] RST_TIMER_PERIOD_LENGTH = 16'h0000;
  localparam logic [15:0] RST_TIMER_COMPARE_THRESHOLD = 16'h0000;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_INVERT_BIT = 1;
  localparam int CTL_CLKSEL_LSB = 2;
  localparam int CTL_CLKSEL_MSB = 3;
  localparam logic [15:0] CTL_WRITE_MASK = 16'h000F;
  localparam logic [1:0] CLKSEL_NONE = 2'h0;
  localparam logic [1:0] CLKSEL_FAST = 2'h1;
  localparam logic [1:0] CLKSEL_MID = 2'h2;
  localparam logic [1:0] CLKSEL_SLOW = 2'h3;
  // ****************************************
  // Timing: tick rates derived from the 40 MHz clock
  // ****************************************
  localparam int REF_CLK_HZ = 40000000;
  localparam int OSC_HZ = 1228800;
  localparam int MID_DIV = 1024;
  localparam int SLOW_DIV = 1024;
  // Fractional accumulator gives exact average 1.2288 MHz
  localparam logic [15:0] ACC_STEP = 16'h0060;
  localparam logic [15:0] ACC_MOD = 16'h0C35;
  localparam int MID_DIV_CYC = MID_DIV;
  localparam int SLOW_DIV_CYC = SLOW_DIV;
endpackage
`default_nettype wire

// ### design/ppt_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module ppt_tick_div
  import ppt_pkg::*;
#(
  parameter int DIV = 1024
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Tick in and out
  input wire logic tick_in,
  output logic tick_out
);
  logic [10:0] cnt_ff;
  logic [10:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (tick_in) begin
      if (cnt_ff == 11'(DIV - 1)) begin
        nxt_cnt = 11'h000;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 11'h001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 11'h000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;
endmodule
`default_nettype wire

// ### verif/ppt_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module ppt_timer_test
  import ppt_pkg::*;
;
  // ****************************************
  // Bench signals
  // ****************************************
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic clkout_sel_timer = 1'b0;
  logic clk_out;
  logic timer_out;
  int n_mismatch = 0;
  int total_checks = 0;
  // Cycles of ref_clk per fast tick; fast tick jitters by one cycle
  real tk = real'(REF_CLK_HZ) / real'(OSC_HZ);
  ppt_timer i_ppt_timer (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .clkout_sel_timer(clkout_sel_timer), .clk_out(clk_out), .timer_out(timer_out));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  function automatic logic sig(input logic pin);
    return pin ? clk_out : timer_out;
  endfunction
  function automatic logic near(input int g, input real e);
    return (real'(g) >= e - 3.0) && (real'(g) <= e + 3.0);
  endfunction
  // Bounded wait; n reaches lim on a hang so the figure fails
  task automatic wait_lvl(input logic pin, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sig(pin) !== v && n < lim);
  endtask
  task automatic meas(input logic pin, input int lim, input bit both, output int hi,
    output int lo);
    int n;
    lo = 0;
    wait_lvl(pin, 1'b0, lim, n);
    wait_lvl(pin, 1'b1, lim, n);
    wait_lvl(pin, 1'b0, lim, hi);
    if (both) begin
      wait_lvl(pin, 1'b1, lim, lo);
    end
  endtask
  task automatic quiet(input logic pin, output int hits);
    hits = 0;
    repeat (400) begin
      @(negedge ref_clk);
      if (sig(pin) !== 1'b0) begin
        hits++;
      end
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [15:0] d;
    int hi;
    int lo;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(ADDR_TIMER_CONTROL + 7'(i), d);
      `CHK("reset value", 16'h0000, d)
    end
    wr(ADDR_TIMER_CONTROL, 16'hFFFF);
    rd(ADDR_TIMER_CONTROL, d);
    `CHK("control", 16'h000F, d)
    wr(ADDR_TIMER_PERIOD_LENGTH, 16'hA5C3);
    wr(ADDR_TIMER_COMPARE_THRESHOLD, 16'h5A3C);
    rd(ADDR_TIMER_PERIOD_LENGTH, d);
    `CHK("period", 16'hA5C3, d)
    rd(ADDR_TIMER_COMPARE_THRESHOLD, d);
    `CHK("threshold", 16'h5A3C, d)
    wr(7'h3E, 16'h1234);
    rd(7'h3E, d);
    `CHK("unmapped", 16'h0000, d)
    // Period 9, threshold 4: six ticks high, four low
    @(posedge ref_clk);
    clkout_sel_timer <= 1'b1;
    wr(ADDR_TIMER_PERIOD_LENGTH, 16'h0009);
    wr(ADDR_TIMER_COMPARE_THRESHOLD, 16'h0004);
    wr(ADDR_TIMER_CONTROL, 16'h0005);
    meas(1'b0, 2000, 1'b1, hi, lo);
    `CHK("high span", 1'b1, near(hi, 6.0 * tk))
    `CHK("low span", 1'b1, near(lo, 4.0 * tk))
    meas(1'b1, 2000, 1'b1, hi, lo);
    `CHK("pin cycle", 1'b1, near(hi + lo, 10.0 * tk))
    wr(ADDR_TIMER_CONTROL, 16'h0007);
    meas(1'b0, 2000, 1'b1, hi, lo);
    `CHK("inverted high", 1'b1, near(hi, 4.0 * tk))
    `CHK("inverted cycle", 1'b1, near(hi + lo, 10.0 * tk))
    @(posedge ref_clk);
    clkout_sel_timer <= 1'b0;
    wr(ADDR_TIMER_CONTROL, 16'h0005);
    quiet(1'b1, hi);
    `CHK("pin unrouted", 0, hi)
    wr(ADDR_TIMER_CONTROL, 16'h0004);
    quiet(1'b0, hi);
    `CHK("disabled", 0, hi)
    wr(ADDR_TIMER_CONTROL, 16'h0001);
    quiet(1'b0, hi);
    `CHK("no clock", 0, hi)
    // Threshold above period never reached
    wr(ADDR_TIMER_COMPARE_THRESHOLD, 16'h0008);
    wr(ADDR_TIMER_PERIOD_LENGTH, 16'h0003);
    wr(ADDR_TIMER_CONTROL, 16'h0005);
    quiet(1'b0, hi);
    `CHK("above period", 0, hi)
    // Mid rate, one tick high; slow rate left out, it runs far too long
    // Stop first so the count starts at zero and the run stays short
    wr(ADDR_TIMER_CONTROL, 16'h0000);
    wr(ADDR_TIMER_PERIOD_LENGTH, 16'h0001);
    wr(ADDR_TIMER_COMPARE_THRESHOLD, 16'h0001);
    wr(ADDR_TIMER_CONTROL, 16'h0009);
    meas(1'b0, 40000, 1'b0, hi, lo);
    `CHK("mid tick", 1'b1, near(hi, real'(MID_DIV) * tk))
    tally_and_finish;
  end
  initial begin
    repeat (95000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
